// ===== fmsp_serial_port.sv
// Four-mode serial port: half-duplex shift-register mode and three full-duplex asynchronous frame modes.
// Assumes the CPU side, timer overflow pulses and config bits come from logic on clock;
// one clock period stands for one oscillator period.
`include "fmsp_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module fmsp_serial_port #(
	parameter int DATA_BITS = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// CPU side of the shared buffer
	input wire logic bufWrite,
	input wire logic [7:0] bufWrData,
	output logic [7:0] bufRdData,
	// Control and status bits
	input wire fmsp_pkg::fmsp_mode_type mode,
	input wire logic rxEnable,
	input wire logic multiprocFilterBit,
	input wire logic txNinthBit,
	input wire logic baudDoubleBit,
	input wire logic sixClockMode,
	input wire logic rxTimer2ClockSel,
	input wire logic txTimer2ClockSel,
	input wire logic clearTxDone,
	input wire logic clearRxDone,
	output logic rxNinthBit,
	output logic txDoneFlag,
	output logic rxDoneFlag,
	output logic serialIrq,
	// Timer overflow pulses
	input wire logic timer1Overflow,
	input wire logic timer2Overflow,
	// Pins
	input wire logic rxdIn,
	output logic rxdOut,
	output logic rxdOe,
	output logic txdOut
);
	import fmsp_pkg::*;

	if (DATA_BITS != 8)
		$error("fmsp_serial_port serves 8 data bits only");

	logic rstA_r, rstSync_r, rxdMeta_r, rxdS_r;
	logic [1:0] m2Cnt_r;
	logic t1Half_r, t1Extra_r;
	logic m2Tick, t1Tick, txTick, rxTick, txBitTick;
	logic [2:0] m2Period;
	logic [3:0] m0Div;
	fmsp_tx_state_type txState_r;
	logic [10:0] txShift_r;
	logic [3:0] txLeft_r, txDiv_r;
	logic txPin_r, txEnd;
	fmsp_rx_state_type rxState_r;
	logic [3:0] rxCnt_r, rxIdx_r;
	logic [8:0] rxShift_r;
	logic rxS7_r, rxS8_r, rxPrev_r, rxBit, rxFinal, rxLoad, rxQual;
	fmsp_shift_state_type shState_r;
	logic [3:0] shPre_r;
	logic [2:0] shCnt_r;
	logic [7:0] shReg_r;
	logic shClk_r, shEnd;

	// Reset release and pin synchroniser
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
		begin
			rstA_r <= 1'b0;
			rstSync_r <= 1'b0;
		end
		else
		begin
			rstA_r <= 1'b1;
			rstSync_r <= rstA_r;
		end

	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
		begin
			rxdMeta_r <= 1'b1;
			rxdS_r <= 1'b1;
		end
		else
		begin
			rxdMeta_r <= rxdIn;
			rxdS_r <= rxdMeta_r;
		end

	// Sixteen-times tick sources
	assign m2Period = sixClockMode ? `FMSP_M2_TICK_6 : `FMSP_M2_TICK_12;
	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
			m2Cnt_r <= 2'h0;
		else if (m2Tick)
			m2Cnt_r <= 2'h0;
		else
			m2Cnt_r <= m2Cnt_r + 2'h1;
	assign m2Tick = baudDoubleBit ? ({1'b0, m2Cnt_r} == (m2Period >> 1) - 3'h1)
		: ({1'b0, m2Cnt_r} == m2Period - 3'h1);

	// Every other Timer 1 overflow unless doubled or in 6-clock mode; 6-clock doubled adds a tick the cycle after,
	// so it needs overflows at least two clocks apart
	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
		begin
			t1Half_r <= 1'b0;
			t1Extra_r <= 1'b0;
		end
		else
		begin
			t1Extra_r <= timer1Overflow & sixClockMode & baudDoubleBit;
			if (timer1Overflow)
				t1Half_r <= ~t1Half_r;
		end
	assign t1Tick = (timer1Overflow & (baudDoubleBit | sixClockMode | t1Half_r)) | t1Extra_r;
	assign txTick = (mode == MODE_UART9_FIXED) ? m2Tick
		: (txTimer2ClockSel ? timer2Overflow : t1Tick);
	assign rxTick = (mode == MODE_UART9_FIXED) ? m2Tick
		: (rxTimer2ClockSel ? timer2Overflow : t1Tick);

	// Asynchronous transmitter; bit times follow the divide-by-16 counter, not the write
	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
			txDiv_r <= 4'h0;
		else if (txTick)
			txDiv_r <= txDiv_r + 4'h1;
	assign txBitTick = txTick && txDiv_r == `FMSP_DIV16_LAST;

	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
		begin
			txState_r <= TX_IDLE;
			txShift_r <= 11'h7FF;
			txLeft_r <= 4'h0;
			txPin_r <= 1'b1;
		end
		else if (bufWrite && mode != MODE_SHIFT)
		begin
			// Ninth slot holds stop in mode 1, programmable bit otherwise
			txState_r <= TX_WAIT;
			// Restart parks the line high until the next rollover
			txPin_r <= 1'b1;
			txShift_r <= {1'b1, (mode == MODE_UART8) | txNinthBit, bufWrData, 1'b0};
		end
		else
		begin
			case (txState_r)
				TX_WAIT:
					if (txBitTick)
					begin
						txState_r <= TX_SEND;
						txPin_r <= txShift_r[0];
						txShift_r <= {1'b0, txShift_r[10:1]};
						txLeft_r <= ((mode == MODE_UART8) ? `FMSP_LEN_M1 : `FMSP_LEN_M23) - 4'h1;
					end
				TX_SEND:
					if (txBitTick)
					begin
						if (txLeft_r == 4'h0)
							txState_r <= TX_IDLE;
						else
						begin
							txPin_r <= txShift_r[0];
							txShift_r <= {1'b0, txShift_r[10:1]};
							txLeft_r <= txLeft_r - 4'h1;
						end
					end
				default:
					txPin_r <= 1'b1;
			endcase
		end
	assign txEnd = (txState_r == TX_SEND) && txBitTick && txLeft_r == 4'h0;

	// Asynchronous receiver, independent of the transmitter
	assign rxBit = (rxS7_r & rxS8_r) | (rxS7_r & rxdS_r) | (rxS8_r & rxdS_r);
	assign rxFinal = rxState_r == RX_FRAME && rxTick && rxCnt_r == `FMSP_SAMPLE_C && rxIdx_r == `FMSP_RX_SHIFTS;
	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
		begin
			rxState_r <= RX_HUNT;
			rxCnt_r <= 4'h0;
			rxIdx_r <= 4'h0;
			rxShift_r <= 9'h1FF;
			rxS7_r <= 1'b1;
			rxS8_r <= 1'b1;
			rxPrev_r <= 1'b0;
		end
		else if (rxTick)
		begin
			case (rxState_r)
				RX_HUNT:
				begin
					rxPrev_r <= rxdS_r;
					if (rxEnable && mode != MODE_SHIFT && rxPrev_r && !rxdS_r)
					begin
						rxState_r <= RX_FRAME;
						rxCnt_r <= 4'h1;
						rxIdx_r <= 4'h0;
						rxShift_r <= 9'h1FF;
					end
				end
				RX_FRAME:
				begin
					rxCnt_r <= rxCnt_r + 4'h1;
					if (rxCnt_r == `FMSP_SAMPLE_A)
						rxS7_r <= rxdS_r;
					if (rxCnt_r == `FMSP_SAMPLE_B)
						rxS8_r <= rxdS_r;
					if (rxCnt_r == `FMSP_SAMPLE_C)
					begin
						if (rxIdx_r == 4'h0)
						begin
							// A high start bit was noise
							if (rxBit)
							begin
								rxState_r <= RX_HUNT;
								rxPrev_r <= 1'b0;
							end
							rxIdx_r <= 4'h1;
						end
						else
						begin
							rxShift_r <= {rxBit, rxShift_r[8:1]};
							rxIdx_r <= rxIdx_r + 4'h1;
							if (rxIdx_r == `FMSP_RX_SHIFTS)
							begin
								// Line must go high again before the next start counts
								rxState_r <= RX_HUNT;
								rxPrev_r <= 1'b0;
							end
						end
					end
				end
				default:
					rxState_r <= RX_HUNT;
			endcase
		end

	// Mode 0 shift engine; a write while it receives is ignored
	assign m0Div = sixClockMode ? `FMSP_M0_DIV_6 : `FMSP_M0_DIV_12;
	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
		begin
			shState_r <= SH_IDLE;
			shPre_r <= 4'h0;
			shCnt_r <= 3'h0;
			shReg_r <= `FMSP_RST_BYTE;
			shClk_r <= 1'b1;
			rxdOut <= 1'b1;
			rxdOe <= 1'b0;
		end
		else
		begin
			case (shState_r)
				SH_IDLE:
				begin
					shPre_r <= 4'h0;
					shCnt_r <= 3'h0;
					shClk_r <= 1'b1;
					rxdOe <= 1'b0;
					if (mode == MODE_SHIFT && bufWrite)
					begin
						shState_r <= SH_TX;
						shReg_r <= bufWrData;
						rxdOut <= bufWrData[0];
						rxdOe <= 1'b1;
						shClk_r <= 1'b0;
					end
					else if (mode == MODE_SHIFT && rxEnable && !rxDoneFlag)
					begin
						shState_r <= SH_RX;
						shClk_r <= 1'b0;
					end
				end
				SH_TX, SH_RX:
				begin
					shPre_r <= shPre_r + 4'h1;
					if (shPre_r == (m0Div >> 1) - 4'h1)
					begin
						shClk_r <= 1'b1;
						if (shState_r == SH_RX)
							shReg_r <= {rxdS_r, shReg_r[7:1]};
					end
					if (shPre_r == m0Div - 4'h1)
					begin
						shPre_r <= 4'h0;
						shCnt_r <= shCnt_r + 3'h1;
						if (shCnt_r == `FMSP_M0_LAST)
						begin
							shState_r <= SH_IDLE;
							rxdOe <= 1'b0;
						end
						else
						begin
							shClk_r <= 1'b0;
							if (shState_r == SH_TX)
							begin
								shReg_r <= {1'b0, shReg_r[7:1]};
								rxdOut <= shReg_r[1];
							end
						end
					end
				end
				default:
					shState_r <= SH_IDLE;
			endcase
		end
	assign shEnd = shState_r != SH_IDLE && shPre_r == m0Div - 4'h1 && shCnt_r == `FMSP_M0_LAST;

	// Receive buffer and flags; a hardware set wins over a clear in the same cycle
	assign rxQual = !multiprocFilterBit || rxBit;
	assign rxLoad = (rxFinal && !rxDoneFlag && rxQual)
		|| (shEnd && shState_r == SH_RX && !rxDoneFlag);
	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
		begin
			bufRdData <= `FMSP_RST_BYTE;
			rxNinthBit <= 1'b0;
		end
		else if (rxLoad)
		begin
			bufRdData <= rxFinal ? rxShift_r[8:1] : shReg_r;
			if (rxFinal)
				rxNinthBit <= rxBit;
		end

	always_ff @(posedge clock or negedge rstSync_r)
		if (!rstSync_r)
		begin
			txDoneFlag <= 1'b0;
			rxDoneFlag <= 1'b0;
		end
		else
		begin
			txDoneFlag <= (txDoneFlag && !clearTxDone) || txEnd || (shEnd && shState_r == SH_TX);
			rxDoneFlag <= (rxDoneFlag && !clearRxDone) || rxLoad;
		end
	assign serialIrq = txDoneFlag | rxDoneFlag;
	assign txdOut = (mode == MODE_SHIFT) ? shClk_r : txPin_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstSync_r);

	sequence s_m2Gap;
		!m2Tick [*3] ##1 m2Tick;
	endsequence
	property p_m2Rate;
		disable iff (!rstSync_r || sixClockMode || baudDoubleBit)
		m2Tick && !sixClockMode && !baudDoubleBit && $stable(baudDoubleBit) |=> s_m2Gap;
	endproperty
	a_m2Rate: assert property (p_m2Rate) else $error("mode 2 tick spacing wrong");
	property p_loadGate;
		rxLoad |-> !rxDoneFlag ##1 rxDoneFlag;
	endproperty
	a_loadGate: assert property (p_loadGate) else $error("receive load with done flag set");
	property p_filter;
		rxFinal && mode != MODE_SHIFT && multiprocFilterBit && !rxBit |-> !rxLoad;
	endproperty
	a_filter: assert property (p_filter) else $error("filtered frame was loaded");
	property p_ninth;
		rxFinal && rxLoad |=> rxNinthBit == $past(rxBit) && bufRdData == $past(rxShift_r[8:1]);
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit or data not stored");
	property p_falseStart;
		rxState_r == RX_FRAME && rxTick && rxCnt_r == `FMSP_SAMPLE_C && rxIdx_r == 4'h0 && rxBit
			|=> rxState_r == RX_HUNT;
	endproperty
	a_falseStart: assert property (p_falseStart) else $error("false start not rejected");
	property p_txDone;
		txEnd |=> txDoneFlag [*2] or (txDoneFlag ##1 $past(clearTxDone));
	endproperty
	a_txDone: assert property (p_txDone) else $error("transmit done flag not held");
	property p_m0Drive;
		shState_r != SH_IDLE && mode == MODE_SHIFT
			|-> rxdOe == (shState_r == SH_TX) && txdOut == (shPre_r >= (m0Div >> 1));
	endproperty
	a_m0Drive: assert property (p_m0Drive) else $error("mode 0 pin drive or clock phase wrong");
	property p_m0Len;
		shState_r == SH_IDLE ##1 shState_r == SH_TX |-> (shState_r == SH_TX) [*8];
	endproperty
	a_m0Len: assert property (p_m0Len) else $error("mode 0 transfer too short");
	property p_idleHigh;
		mode != MODE_SHIFT && txState_r == TX_IDLE |-> txdOut;
	endproperty
	a_idleHigh: assert property (p_idleHigh) else $error("idle line not high");
endmodule
`default_nettype wire

// ===== fmsp_defs.svh
// Constants of the four-mode serial port: divisors, counter states, frame lengths, reset values.
// Assumes the including file uses them at the widths given here.
`ifndef FMSP_DEFS_SVH
`define FMSP_DEFS_SVH
`define FMSP_M0_DIV_12 4'hC
`define FMSP_M0_DIV_6 4'h6
`define FMSP_M2_TICK_12 3'h4
`define FMSP_M2_TICK_6 3'h2
`define FMSP_DIV16_LAST 4'hF
`define FMSP_SAMPLE_A 4'h7
`define FMSP_SAMPLE_B 4'h8
`define FMSP_SAMPLE_C 4'h9
`define FMSP_RX_SHIFTS 4'h9
`define FMSP_M0_LAST 3'h7
`define FMSP_LEN_M1 4'hA
`define FMSP_LEN_M23 4'hB
`define FMSP_RST_BYTE 8'h00
`endif

// ===== fmsp_pkg.sv
// Types of the four-mode serial port.
// Assumes nothing beyond a SystemVerilog compiler.
package fmsp_pkg;
	typedef enum logic [1:0] {MODE_SHIFT = 2'b00, MODE_UART8 = 2'b01, MODE_UART9_FIXED = 2'b10,
		MODE_UART9_TIMER = 2'b11} fmsp_mode_type;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b10} fmsp_tx_state_type;
	typedef enum logic {RX_HUNT = 1'b0, RX_FRAME = 1'b1} fmsp_rx_state_type;
	typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_TX = 2'b01, SH_RX = 2'b10} fmsp_shift_state_type;
endpackage

// ===== fmsp_peer.sv
// Remote serial node: sends frames on its line, captures frames from the port's txd,
// and answers mode 0 shift clocks with data bits.
// Assumes bit times in whole clock cycles and an idle-high line.
`timescale 1ns/100ps
`default_nettype none
module fmsp_peer (
	// Clock
	input wire logic clock,
	// Lines
	input wire logic txdLine,
	output logic peerLine
);
	logic [10:0] capBits;
	logic capTimeout;
	initial
	begin
		peerLine = 1'b1;
		capBits = 11'h000;
		capTimeout = 1'b0;
	end
	// Start 0, data LSB first, ninth or stop, then idle high
	task automatic send_frame(input logic [10:0] bits, input int nBits, input int bitLen);
		for (int i = 0; i < nBits; i++)
		begin
			peerLine <= bits[i];
			repeat (bitLen) @(posedge clock);
		end
		peerLine <= 1'b1;
	endtask
	// Mid-bit sampling hides a one-cycle edge offset
	task automatic capture(input int nBits, input int bitLen);
		int n;
		n = 0;
		capTimeout = 1'b0;
		while (txdLine === 1'b1 && n < 4000)
		begin
			@(posedge clock);
			n++;
		end
		capTimeout = (n >= 4000);
		repeat (bitLen / 2) @(posedge clock);
		for (int i = 0; i < nBits; i++)
		begin
			capBits[i] = txdLine;
			repeat (bitLen) @(posedge clock);
		end
		#1;
	endtask
	// Mode 0 partner: presents the next bit after each rising shift clock
	task automatic shift_out(input logic [7:0] bits);
		logic prev;
		int k, n;
		prev = 1'b1;
		k = 0;
		n = 0;
		peerLine <= bits[0];
		while (k < 8 && n < 400)
		begin
			@(posedge clock);
			#1 n++;
			if (!prev && txdLine)
			begin
				k++;
				if (k < 8)
					peerLine <= bits[k];
			end
			prev = txdLine;
		end
		peerLine <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== four_mode_serial_port_test.sv
// Self-checking bench of the four-mode serial port.
// Assumes both timer sources pulse every cycle, so timer-clocked async bits are 16 or 32 clocks.
`timescale 1ns/100ps
`default_nettype none
module four_mode_serial_port_test;
	import fmsp_pkg::*;
	logic clock, resetn, bufWrite, rxEnable, filt, ninth, dbl, six, rxT2, txT2, clrTx, clrRx, t1Ov, t2Ov;
	logic [7:0] bufWrData, bufRdData;
	fmsp_mode_type mode;
	logic rxNinthBit, txDoneFlag, rxDoneFlag, serialIrq, rxdOut, rxdOe, txdOut, peerLine, rxdWire;
	int failures, nChecks;
	assign rxdWire = rxdOe ? rxdOut : peerLine;
	fmsp_serial_port uut (.clock(clock), .resetn(resetn), .bufWrite(bufWrite), .bufWrData(bufWrData),
		.bufRdData(bufRdData), .mode(mode), .rxEnable(rxEnable), .multiprocFilterBit(filt),
		.txNinthBit(ninth), .baudDoubleBit(dbl), .sixClockMode(six), .rxTimer2ClockSel(rxT2),
		.txTimer2ClockSel(txT2), .clearTxDone(clrTx), .clearRxDone(clrRx), .rxNinthBit(rxNinthBit),
		.txDoneFlag(txDoneFlag), .rxDoneFlag(rxDoneFlag), .serialIrq(serialIrq), .timer1Overflow(t1Ov),
		.timer2Overflow(t2Ov), .rxdIn(rxdWire), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut));
	fmsp_peer peer (.clock(clock), .txdLine(txdOut), .peerLine(peerLine));
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", nChecks, failures);
		if (failures == 0 && nChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, seen);
			failures++;
		end
	endtask
	task automatic write_buf(input logic [7:0] d);
		bufWrData = d;
		bufWrite = 1'b1;
		@(posedge clock);
		#1 bufWrite = 1'b0;
	endtask
	task automatic pulse_clear();
		clrTx = 1'b1;
		clrRx = 1'b1;
		@(posedge clock);
		#1 clrTx = 1'b0;
		clrRx = 1'b0;
	endtask
	task automatic wait_tx();
		int n;
		n = 0;
		while (txDoneFlag !== 1'b1 && n < 2000)
		begin
			@(posedge clock);
			#1 n++;
		end
		if (n >= 2000)
		begin
			failures++;
			complete_run();
		end
	endtask
	task automatic bail(input logic expired);
		if (expired)
		begin
			failures++;
			complete_run();
		end
	endtask
	// Rate errors drift the mid-bit samples off the data
	task automatic tx_async(input fmsp_mode_type m, input logic s6, input logic d, input logic t2,
		input logic [7:0] data, input logic nin, input int nb, input int bitLen);
		mode = m;
		six = s6;
		dbl = d;
		txT2 = t2;
		ninth = nin;
		write_buf(data);
		peer.capture(nb, bitLen);
		check("tx timeout", peer.capTimeout, 1'b0);
		bail(peer.capTimeout);
		check("tx start", peer.capBits[0], 1'b0);
		check("tx data", peer.capBits[8:1], data);
		check("tx ninth", peer.capBits[9], nb == 11 ? nin : 1'b1);
		check("tx stop", peer.capBits[nb - 1], 1'b1);
		wait_tx();
		check("tx done irq", {txDoneFlag, serialIrq}, 2'b11);
		pulse_clear();
		check("tx done clear", {txDoneFlag, serialIrq}, 2'b00);
	endtask
	task automatic rx_frame(input fmsp_mode_type m, input logic en, input logic f, input logic [7:0] data,
		input logic nin, input logic expFlag, input logic [7:0] expData, input logic expNin, input logic clr);
		mode = m;
		rxEnable = en;
		filt = f;
		peer.send_frame({1'b1, nin, data, 1'b0}, m == MODE_UART8 ? 10 : 11, 16);
		repeat (20) @(posedge clock);
		#1 check("rx flag irq", {rxDoneFlag, serialIrq}, {expFlag, expFlag});
		check("rx data", bufRdData, expData);
		check("rx ninth", rxNinthBit, expNin);
		if (clr)
			pulse_clear();
	endtask
	task automatic shift_tx(input logic s6, input int period, input logic [7:0] data);
		logic [7:0] got;
		logic prev;
		int k, last, n;
		rxEnable = 1'b0;
		mode = MODE_SHIFT;
		six = s6;
		write_buf(data);
		prev = 1'b1;
		k = 0;
		last = 0;
		n = 0;
		while (k < 8 && n < 200)
		begin
			@(posedge clock);
			#1 n++;
			if (prev === 1'b0 && txdOut === 1'b1)
			begin
				got[k] = rxdOut;
				check("shift oe", rxdOe, 1'b1);
				if (k > 0)
					check("shift period", 11'(n - last), 11'(period));
				last = n;
				k++;
			end
			prev = txdOut;
		end
		check("shift data", got, data);
		bail(k < 8);
		wait_tx();
		check("shift done", txDoneFlag, 1'b1);
		pulse_clear();
	endtask
	// Filter set on purpose: it must not block a mode 0 load
	task automatic shift_rx(input logic [7:0] data);
		int n;
		n = 0;
		mode = MODE_SHIFT;
		filt = 1'b1;
		rxEnable = 1'b1;
		peer.shift_out(data);
		while (rxDoneFlag !== 1'b1 && n < 100)
		begin
			@(posedge clock);
			#1 n++;
		end
		check("shift rx flag irq", {rxDoneFlag, serialIrq}, 2'b11);
		check("shift rx data", bufRdData, data);
		check("shift rx ninth", rxNinthBit, 1'b1);
		bail(n >= 100);
		rxEnable = 1'b0;
		pulse_clear();
	endtask
	// A short low pulse; without rejection an all-ones frame would load well inside the wait
	task automatic false_start();
		mode = MODE_UART8;
		rxEnable = 1'b1;
		filt = 1'b0;
		peer.send_frame(11'h7FE, 1, 4);
		repeat (200) @(posedge clock);
		#1 check("rx glitch", {rxDoneFlag, bufRdData}, {1'b0, 8'hA7});
	endtask
	initial
	begin
		failures = 0;
		nChecks = 0;
		{bufWrite, rxEnable, filt, ninth, dbl, six, rxT2, txT2, clrTx, clrRx, resetn} = 11'h000;
		{t1Ov, t2Ov} = 2'b11;
		bufWrData = 8'h00;
		mode = MODE_UART8;
		repeat (5) @(posedge clock);
		#1 resetn = 1'b1;
		repeat (4) @(posedge clock);
		#1 check("reset outs", {bufRdData, txDoneFlag, rxDoneFlag, rxdOe}, 11'h000);
		tx_async(MODE_UART9_FIXED, 1'b1, 1'b1, 1'b0, 8'hA5, 1'b1, 11, 16);
		tx_async(MODE_UART9_FIXED, 1'b0, 1'b0, 1'b0, 8'h4B, 1'b0, 11, 64);
		tx_async(MODE_UART9_TIMER, 1'b0, 1'b0, 1'b0, 8'hC3, 1'b1, 11, 32);
		tx_async(MODE_UART8, 1'b0, 1'b0, 1'b1, 8'h5E, 1'b0, 10, 16);
		rxT2 = 1'b1;
		rx_frame(MODE_UART8, 1'b0, 1'b0, 8'h77, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		rx_frame(MODE_UART8, 1'b1, 1'b0, 8'h3C, 1'b1, 1'b1, 8'h3C, 1'b1, 1'b1);
		rx_frame(MODE_UART8, 1'b1, 1'b1, 8'h66, 1'b0, 1'b0, 8'h3C, 1'b1, 1'b0);
		rx_frame(MODE_UART9_TIMER, 1'b1, 1'b1, 8'h5A, 1'b0, 1'b0, 8'h3C, 1'b1, 1'b0);
		rx_frame(MODE_UART9_TIMER, 1'b1, 1'b1, 8'hA7, 1'b1, 1'b1, 8'hA7, 1'b1, 1'b0);
		rx_frame(MODE_UART9_TIMER, 1'b1, 1'b0, 8'h11, 1'b0, 1'b1, 8'hA7, 1'b1, 1'b1);
		false_start();
		shift_tx(1'b1, 6, 8'h96);
		shift_tx(1'b0, 12, 8'h3A);
		shift_rx(8'hC5);
		complete_run();
	end
endmodule
`default_nettype wire
